/* File: smcp_host.sv */
// host model: drives select, shift clock, qualifiers and the data line
`timescale 1ns/10ps
module smcp_host
    import smcp_pkg::*;
(
    // pattern clock
    input  wire logic                 clk,
    // device side of the data line
    input  wire logic                 dev_o,
    input  wire logic                 dev_oe,
    // host pins
    output      logic                 cs_b,
    output      logic                 sck,
    output      logic                 serial_io_line,
    output      smcp_pkg::smcp_qual_t qual
);
    logic host_oe_q;
    logic host_d_q;
    logic last_q;
    // released line shows the inverse of its last driven level
    always @(posedge clk) begin
        if (dev_oe === 1'b1) begin
            last_q <= dev_o;
        end else if (host_oe_q) begin
            last_q <= host_d_q;
        end
    end
    assign serial_io_line = (dev_oe === 1'b1) ? dev_o : (host_oe_q ? host_d_q : ~last_q);
    initial begin
        cs_b = 1'b1;
        sck = 1'b0;
        qual = '0;
        host_oe_q = 1'b1;
        host_d_q = 1'b0;
    end
    task automatic frame(input smcp_qual_t q, input logic [31:0] d, input int n,
                         output logic [15:0] rd);
        rd = 16'h0000;
        qual = q;
        host_oe_q = ~q.rw;
        #100 cs_b = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            host_d_q = d[i];
            #32 sck = 1'b1;
            rd = {rd[14:0], serial_io_line};
            #32 sck = 1'b0;
        end
        #200 cs_b = 1'b1;
        #200 host_oe_q = 1'b0;
        #400;
    endtask : frame
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            host_d_q = ~host_d_q;
            #32 sck = 1'b1;
            #32 sck = 1'b0;
        end
        #600;
    endtask : stray
endmodule : smcp_host

/* File: smcp_pkg.sv */
// types and constants for the serial command port
package smcp_pkg;

    // word layout
    localparam int SMCP_WORD_W   = 16;
    localparam int SMCP_PI_W     = 8;
    localparam int SMCP_KEY_W    = 12;
    localparam int SMCP_AC_W     = 6;
    localparam int SMCP_RAM_W    = 8;
    localparam int SMCP_BUSY_BIT = 6;

    // qualifier codes {transfer_type_bit, rw, register_select_line} of reads
    localparam logic [2:0] SMCP_RD_PORT = 3'h2;
    localparam logic [2:0] SMCP_RD_KEY  = 3'h3;
    localparam logic [2:0] SMCP_RD_STAT = 3'h6;
    localparam logic [2:0] SMCP_RD_RAM  = 3'h7;

    typedef enum logic [0:0] {
        SMCP_IDLE = 1'b0,
        SMCP_XFER = 1'b1
    } smcp_state_t;

    typedef struct packed {
        logic transfer_type_bit;
        logic rw;
        logic register_select_line;
    } smcp_qual_t;

    // every pin that crosses into the clk domain
    typedef struct packed {
        logic                 cs_b;
        logic                 sck;
        logic                 sdi;
        smcp_qual_t           qual;
        logic [SMCP_PI_W-1:0] pi;
    } smcp_pin_t;

    // parallel word handed to the instruction logic
    typedef struct packed {
        logic [SMCP_WORD_W-1:0] word;
        smcp_qual_t             qual;
        logic                   valid;
    } smcp_cmd_t;

    // read-back sources from the rest of the device
    typedef struct packed {
        logic                  internal_busy_flag;
        logic [SMCP_AC_W-1:0]  ac;
        logic [SMCP_KEY_W-1:0] keys;
        logic [SMCP_RAM_W-1:0] ram;
    } smcp_rd_t;

    typedef struct packed {
        smcp_state_t            state;
        smcp_pin_t              s1;
        smcp_pin_t              s2;
        smcp_pin_t              s3;
        smcp_pin_t              f;
        logic [SMCP_WORD_W-1:0] in_sr;
        logic [SMCP_WORD_W-1:0] out_sr;
        smcp_cmd_t              cmd;
        logic                   sio_o;
        logic                   sio_oe;
    } smcp_st_t;

    localparam smcp_pin_t SMCP_PIN_RST = smcp_pin_t'(14'h2000);

    localparam smcp_st_t SMCP_ST_RST = '{
        state  : SMCP_IDLE,
        s1     : SMCP_PIN_RST,
        s2     : SMCP_PIN_RST,
        s3     : SMCP_PIN_RST,
        f      : SMCP_PIN_RST,
        in_sr  : 16'h0000,
        out_sr : 16'h0000,
        cmd    : smcp_cmd_t'(20'h00000),
        sio_o  : 1'b0,
        sio_oe : 1'b0
    };

endpackage : smcp_pkg

/* File: smcp_port.sv */
// serial instruction port: select-framed 16-bit shift in and read-back out
//
// Overview of operation
// - port acts only while select is low; clock and data ignored otherwise
// - words move most significant bit first, bit 15 down to bit 0
// - incoming data bit shifts in on rising edge of shift clock
// - select rising hands shift register to instruction logic as one word
// - beyond sixteen bits in one frame, only the final sixteen are kept
// - read data bits leave on falling edge of shift clock
// - input pins are frozen into the read word at select falling
// - status read gives busy flag in bit 6, address counter below
`timescale 1ns/10ps
module smcp_port
    import smcp_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // host pins
    input  wire logic                        cs_b,
    input  wire logic                        sck,
    input  wire logic                        serial_io_line_i,
    output      logic                        serial_io_line_o,
    output      logic                        serial_io_line_oe,
    input  wire smcp_pkg::smcp_qual_t        qual_i,
    // input port pins
    input  wire logic [smcp_pkg::SMCP_PI_W-1:0] in_port_i,
    // read-back sources
    input  wire smcp_pkg::smcp_rd_t          rd_i,
    // instruction word out
    output      smcp_pkg::smcp_cmd_t         cmd_o
);
    import smcp_pkg::*;

    smcp_st_t st_q;
    smcp_st_t st_d;
    smcp_pin_t pins;
    smcp_pin_t f_n;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic [SMCP_WORD_W-1:0] rd_word;

    assign pins = '{
        cs_b : cs_b,
        sck  : sck,
        sdi  : serial_io_line_i,
        qual : qual_i,
        pi   : in_port_i
    };

    // a pin level counts once the second and third stages agree
    assign f_n = (st_q.s2 & st_q.s3) | (st_q.f & (st_q.s2 ^ st_q.s3));

    assign cs_fall  = st_q.f.cs_b & ~f_n.cs_b;
    assign cs_rise  = ~st_q.f.cs_b & f_n.cs_b;
    assign sck_rise = ~st_q.f.sck & f_n.sck;
    assign sck_fall = st_q.f.sck & ~f_n.sck;

    // word to send back, chosen by the qualifiers seen at select falling
    always_comb begin
        case (f_n.qual)
            SMCP_RD_PORT: rd_word = {8'h00, f_n.pi};
            SMCP_RD_KEY:  rd_word = {4'h0, rd_i.keys};
            SMCP_RD_STAT: rd_word = {9'h000, rd_i.internal_busy_flag, rd_i.ac};
            SMCP_RD_RAM:  rd_word = {8'h00, rd_i.ram};
            default:      rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        st_d           = st_q;
        st_d.s1        = pins;
        st_d.s2        = st_q.s1;
        st_d.s3        = st_q.s2;
        st_d.f         = f_n;
        st_d.cmd.valid = 1'b0;
        case (st_q.state)
            SMCP_IDLE: begin
                st_d.sio_oe = 1'b0;
                if (cs_fall) begin
                    st_d.state    = SMCP_XFER;
                    st_d.cmd.qual = f_n.qual;
                    if (f_n.qual.rw) begin
                        st_d.out_sr = rd_word;
                        st_d.sio_o  = rd_word[SMCP_WORD_W-1];
                        st_d.sio_oe = 1'b1;
                    end
                end
            end
            SMCP_XFER: begin
                if (cs_rise) begin
                    st_d.state     = SMCP_IDLE;
                    st_d.sio_oe    = 1'b0;
                    st_d.cmd.word  = st_q.in_sr;
                    st_d.cmd.valid = 1'b1;
                end else begin
                    if (sck_rise) begin
                        // older bits fall off the top, so the last 16 remain
                        st_d.in_sr = {st_q.in_sr[SMCP_WORD_W-2:0], f_n.sdi};
                    end
                    if (sck_fall && st_q.cmd.qual.rw) begin
                        st_d.out_sr = {st_q.out_sr[SMCP_WORD_W-2:0], 1'b0};
                        st_d.sio_o  = st_q.out_sr[SMCP_WORD_W-2];
                    end
                end
            end
            default: begin
                st_d = SMCP_ST_RST;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= SMCP_ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign serial_io_line_o  = st_q.sio_o;
    assign serial_io_line_oe = st_q.sio_oe;
    assign cmd_o             = st_q.cmd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_IDLE_RELEASED: assert property (
        st_q.state == SMCP_IDLE |-> !st_q.sio_oe
    ) else $error("data line driven while select high");

    AST_WRITE_RELEASED: assert property (
        (st_q.state == SMCP_XFER && !st_q.cmd.qual.rw) |-> !st_q.sio_oe
    ) else $error("data line driven during a write");

    AST_IDLE_IGNORES: assert property (
        ($past(st_q.state) == SMCP_IDLE && st_q.state == SMCP_IDLE)
            |-> st_q.in_sr == $past(st_q.in_sr)
    ) else $error("shift register moved while select high");

    AST_RISE_DELIVERS: assert property (
        ($past(st_q.state) == SMCP_XFER && $rose(st_q.f.cs_b))
            |-> st_q.cmd.valid && st_q.cmd.word == $past(st_q.in_sr)
    ) else $error("word not delivered at select rising");

    AST_VALID_ONE_CYCLE: assert property (
        st_q.cmd.valid |=> !st_q.cmd.valid ##1 !st_q.cmd.valid
    ) else $error("word strobe longer than one cycle");

    AST_SHIFT_IN_RISE: assert property (
        ($past(st_q.state) == SMCP_XFER && st_q.state == SMCP_XFER
            && $rose(st_q.f.sck))
            |-> st_q.in_sr == {$past(st_q.in_sr[14:0]), st_q.f.sdi}
    ) else $error("bit not shifted in at clock rising");

    AST_SHIFT_OUT_FALL: assert property (
        ($past(st_q.state) == SMCP_XFER && st_q.state == SMCP_XFER
            && $fell(st_q.f.sck) && st_q.cmd.qual.rw)
            |-> st_q.sio_o == $past(st_q.out_sr[14])
    ) else $error("next bit not driven at clock falling");

    AST_STATUS_WORD: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual == SMCP_RD_STAT)
            |-> st_q.out_sr[SMCP_BUSY_BIT] == $past(rd_i.internal_busy_flag)
                && st_q.out_sr[5:0] == $past(rd_i.ac) && st_q.sio_oe
    ) else $error("status word wrong");

    AST_PORT_FROZEN: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual == SMCP_RD_PORT)
            |-> st_q.out_sr[7:0] == st_q.f.pi
                ##1 (st_q.out_sr[7:0] == $past(st_q.out_sr[7:0])
                     || $fell(st_q.f.sck) || $rose(st_q.f.cs_b))
    ) else $error("input port not captured at select falling");

    AST_FRAME_START: assert property (
        $fell(st_q.f.cs_b) |-> st_q.state == SMCP_XFER
    ) else $error("frame not opened at select falling");

    AST_FRAME_END: assert property (
        $rose(st_q.f.cs_b) |-> st_q.state == SMCP_IDLE
    ) else $error("frame not closed at select rising");

    AST_QUAL_LATCHED: assert property (
        $fell(st_q.f.cs_b) |-> st_q.cmd.qual == st_q.f.qual
    ) else $error("qualifiers not taken at select falling");

    AST_READ_FIRST_BIT: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual.rw)
            |-> st_q.sio_oe && st_q.sio_o == st_q.out_sr[SMCP_WORD_W-1]
    ) else $error("top bit not driven at read start");

    AST_READ_DRIVEN: assert property (
        (st_q.state == SMCP_XFER && st_q.cmd.qual.rw) |-> st_q.sio_oe
    ) else $error("data line dropped during a read");

    AST_OUT_HOLDS: assert property (
        ($past(st_q.state) == SMCP_XFER && st_q.state == SMCP_XFER && !$fell(st_q.f.sck))
            |-> $stable(st_q.sio_o)
    ) else $error("output bit moved without clock falling");

    AST_SHIFT_HOLDS: assert property (
        ($past(st_q.state) == SMCP_XFER && st_q.state == SMCP_XFER && !$rose(st_q.f.sck))
            |-> $stable(st_q.in_sr)
    ) else $error("shift register moved without clock rising");

    AST_KEY_WORD: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual == SMCP_RD_KEY)
            |-> st_q.out_sr == {4'h0, $past(rd_i.keys)}
    ) else $error("key word not captured at select falling");

    AST_RAM_WORD: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual == SMCP_RD_RAM)
            |-> st_q.out_sr == {8'h00, $past(rd_i.ram)}
    ) else $error("memory word not captured at select falling");

    AST_STATUS_UPPER: assert property (
        ($fell(st_q.f.cs_b) && st_q.f.qual == SMCP_RD_STAT)
            |-> st_q.out_sr[SMCP_WORD_W-1:7] == 9'h000
    ) else $error("status upper bits not zero");

    AST_VALID_AT_END: assert property (
        st_q.cmd.valid |-> st_q.state == SMCP_IDLE && $rose(st_q.f.cs_b)
    ) else $error("word strobe outside select rising");

    AST_WORD_HOLDS: assert property (
        !st_q.cmd.valid |-> $stable(st_q.cmd.word)
    ) else $error("delivered word changed without strobe");

endmodule : smcp_port

/* File: test_smcp_port.sv */
// testbench for the serial command port
`timescale 1ns/10ps
module test_smcp_port;
    import smcp_pkg::*;
    logic        clk, rst_b, cs_b, sck, serial_io_line, sio_o, sio_oe, bad_oe;
    logic [7:0]  pins;
    logic [15:0] got_word, rbits;
    smcp_qual_t  qual, got_qual;
    smcp_rd_t    rd;
    smcp_cmd_t   cmd;
    int          num_errors = 0, n_tests = 0, n_valid = 0, cycles = 0;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    smcp_port i_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .serial_io_line_i(serial_io_line),
        .serial_io_line_o(sio_o), .serial_io_line_oe(sio_oe), .qual_i(qual),
        .in_port_i(pins), .rd_i(rd), .cmd_o(cmd));
    smcp_host i_host (.clk(clk), .dev_o(sio_o), .dev_oe(sio_oe), .cs_b(cs_b), .sck(sck),
        .serial_io_line(serial_io_line), .qual(qual));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cmd.valid === 1'b1) begin
            n_valid <= n_valid + 1;
            got_word <= cmd.word;
            got_qual <= cmd.qual;
        end
        if (rst_b && sio_oe !== 1'b0 && qual.rw !== 1'b1) bad_oe <= 1'b1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic write_word(input logic [31:0] d, input int n, input logic [15:0] exp);
        int v;
        v = n_valid;
        i_host.frame(smcp_qual_t'(3'h1), d, n, rbits);
        chk("valid count", n_valid - v, 1);
        chk("word", got_word, exp);
        chk("qual", got_qual, 3'h1);
    endtask : write_word
    task automatic test_write();
        write_word(32'hc3a5, 16, 16'hc3a5);
        write_word(32'h5a0f, 16, 16'h5a0f);
    endtask : test_write
    task automatic test_overrun();
        write_word(32'hb1234, 20, 16'h1234);
    endtask : test_overrun
    task automatic test_stray();
        int v;
        v = n_valid;
        i_host.stray(5);
        chk("valid idle", n_valid - v, 0);
        write_word(32'h7e, 8, 16'h347e);
    endtask : test_stray
    task automatic test_reads();
        logic [2:0]  codes [4] = '{SMCP_RD_PORT, SMCP_RD_KEY, SMCP_RD_STAT, SMCP_RD_RAM};
        logic [15:0] exps [4] = '{16'h0096, 16'h0a5c, 16'h006a, 16'h003c};
        for (int k = 0; k < 4; k++) begin
            pins = 8'h96;
            fork
                i_host.frame(smcp_qual_t'(codes[k]), 32'hffff, 16, rbits);
                begin
                    #300;
                    @(posedge clk);
                    #1.25 pins = 8'h69;
                end
            join
            chk("read word", rbits, exps[k]);
            chk("line released", sio_oe, 0);
            chk("read qual", got_qual, codes[k]);
        end
    endtask : test_reads
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    initial begin
        rst_b = 1'b0;
        bad_oe = 1'b0;
        pins = 8'h96;
        rd = '{internal_busy_flag: 1'b1, ac: 6'h2a, keys: 12'ha5c, ram: 8'h3c};
        repeat (20) @(posedge clk);
        #1.25 rst_b = 1'b1;
        chk("cmd after reset", cmd, 0);
        test_write();
        test_overrun();
        test_stray();
        test_reads();
        chk("oe outside reads", bad_oe, 0);
        test_done();
    end
endmodule : test_smcp_port
